// file: logic/smbus_pkg.sv
// Shared constants and state types for the SMBus word slave and its master.
// Assumes a 100 MHz system clock on both ends.
package smbus_pkg;

  // Addressing and framing
  localparam logic [6:0] DEV_ADDR      = 7'h09;
  localparam logic       DIR_WRITE     = 1'h0;
  localparam logic       DIR_READ      = 1'h1;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT      = 4'h8;

  // Register addresses that feed the charge watchdog
  localparam logic [7:0] REG_CHARGE_SETPOINT = 8'h14;
  localparam logic [7:0] REG_VOLTAGE_CEILING = 8'h15;

  // Values after reset, and the word read from an unmapped register
  localparam logic [15:0] SETPOINT_RESET = 16'h0000;
  localparam logic [15:0] CEILING_RESET  = 16'h0000;
  localparam logic [15:0] UNMAPPED_READ  = 16'h0000;

  // Timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SCL_PERIOD_NS = 10000;
  localparam logic [15:0] SCL_QUARTER_CYCLES =
    16'(SCL_PERIOD_NS / (4 * CLK_PERIOD_NS));
  localparam longint unsigned WATCHDOG_S = 175;
  localparam logic [35:0] WATCHDOG_CYCLES =
    36'(WATCHDOG_S * 64'd1000000000 / 64'(CLK_PERIOD_NS));

  // Device bus sequencer states
  typedef enum {
    D_IDLE, D_ADDR, D_REG, D_WLO, D_WHI, D_RLO, D_RHI, D_IGNORE
  } dev_state_t;

  // Master sequencer states
  typedef enum {
    H_IDLE, H_START, H_BYTE, H_STOP
  } host_state_t;

endpackage : smbus_pkg

// file: logic/smbus_link_if.sv
// Two-wire open-drain link between the SMBus master and the word slave.
// Assumes pull-ups: a line is low whenever any enabled driver pulls it.
interface smbus_link_if;
  logic scl;
  logic sda;
  logic host_scl_out;
  logic host_scl_oe;
  logic host_sda_out;
  logic host_sda_oe;
  logic dev_sda_out;
  logic dev_sda_oe;

  // Wired-AND resolution of both lines
  assign scl = ~(host_scl_oe & ~host_scl_out);
  assign sda = ~((host_sda_oe & ~host_sda_out) |
                 (dev_sda_oe & ~dev_sda_out));

  modport host (
    output host_scl_out, host_scl_oe, host_sda_out, host_sda_oe,
    input  scl, sda
  );

  modport device (
    output dev_sda_out, dev_sda_oe,
    input  scl, sda
  );
endinterface : smbus_link_if

// file: logic/bit_sync.sv
// Three-stage level synchroniser with agreement filter.
// Assumes i_async is foreign to i_clk; output moves only when stages agree.
module bit_sync #(
  parameter logic RESET_VAL = 1'h0
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_reset,
  // Level in and out
  input  wire logic i_async,
  output logic      o_level
);

  logic meta;
  logic stage2;
  logic stage3;

  // Shift chain; meta feeds only stage2
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      meta   <= RESET_VAL;
      stage2 <= RESET_VAL;
      stage3 <= RESET_VAL;
    end else begin
      meta   <= i_async;
      stage2 <= meta;
      stage3 <= stage2;
    end
  end

  // Accept a change once two settled stages agree
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_level <= RESET_VAL;
    end else if (stage2 == stage3) begin
      o_level <= stage3;
    end
  end

endmodule : bit_sync

// file: logic/smbus_device.sv
// Word-wide SMBus slave: address match, register pointer, two-byte
// reads and writes, plus the charge inactivity watchdog.
// Assumes the link side runs on i_link_clk and a master clocks the bus.
// Overview of operation
// - SDA changes only while SCL low
// - SDA fall with SCL high starts
// - SDA rise with SCL high stops
// - Master sends STOP before each START
// - Each byte takes nine clocks with acknowledge
// - Master sends address then direction bit
// - Matching address acknowledged in ninth clock
// - Only seven-bit address 0001001 is answered
// - Direction bit: zero writes, one reads
// - Mismatch or not ready leaves SDA released
// - Second byte selects the register
// - Register address byte is always acknowledged
// - Eight bits, MSB first, then acknowledge
// - Low byte precedes high byte
// - Write-word and read-word transfers only
// - Every register is sixteen bits wide
// - Device never starts transfers nor drives SCL
// - Control bytes are 0x13 read, 0x12 write
// - Traffic ignored until reset has completed
// - Charging ends after 175 s without setpoint or ceiling writes
module smbus_device #(
  parameter logic [35:0] WATCHDOG_CYCLES = smbus_pkg::WATCHDOG_CYCLES
) (
  // System clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_reset,
  // Link clock and pins
  input  wire logic          i_link_clk,
  smbus_link_if.device       link,
  // Completed register writes
  output logic               o_write_valid,
  output logic [7:0]         o_write_reg,
  output logic [15:0]        o_write_data,
  // Charger control
  output logic               o_charge_enable
);

  smbus_pkg::dev_state_t state;
  logic        link_rst;
  logic        scl_f;
  logic        sda_f;
  logic        scl_q;
  logic        sda_q;
  logic        start_seen;
  logic        stop_seen;
  logic        scl_rise;
  logic        scl_fall;
  logic [3:0]  bit_cnt;
  logic [7:0]  shreg;
  logic [7:0]  tx;
  logic [7:0]  ptr;
  logic [7:0]  lo_byte;
  logic        master_ack;
  logic        sda_oe;
  logic        addr_hit;
  logic        commit;
  logic [15:0] rd_word;
  logic [15:0] setpoint;
  logic [15:0] ceiling;
  logic [7:0]  wr_reg;
  logic [15:0] wr_data;
  logic        wr_tgl;
  logic        tgl_s;
  logic        tgl_q;
  logic [35:0] wd_cnt;

  // Reset into the link domain; bus is ignored while it is held
  bit_sync #(.RESET_VAL(1'h1)) u_rst_sync (
    .i_clk   (i_link_clk),
    .i_reset (1'h0),
    .i_async (i_reset),
    .o_level (link_rst)
  );

  // Pin inputs, filtered
  bit_sync #(.RESET_VAL(1'h1)) u_scl_sync (
    .i_clk   (i_link_clk),
    .i_reset (link_rst),
    .i_async (link.scl),
    .o_level (scl_f)
  );

  bit_sync #(.RESET_VAL(1'h1)) u_sda_sync (
    .i_clk   (i_link_clk),
    .i_reset (link_rst),
    .i_async (link.sda),
    .o_level (sda_f)
  );

  // Previous line levels for edge detection
  always_ff @(posedge i_link_clk) begin
    if (link_rst) begin
      scl_q <= 1'h1;
      sda_q <= 1'h1;
    end else begin
      scl_q <= scl_f;
      sda_q <= sda_f;
    end
  end

  // Bus conditions and clock edges
  assign start_seen = scl_q & scl_f & sda_q & ~sda_f;
  assign stop_seen  = scl_q & scl_f & ~sda_q & sda_f;
  assign scl_rise   = ~scl_q & scl_f;
  assign scl_fall   = scl_q & ~scl_f;

  // Address match on the received control byte
  assign addr_hit = (shreg[7:1] == smbus_pkg::DEV_ADDR);

  // Full write word arrived, high byte last
  assign commit = scl_fall && (bit_cnt == smbus_pkg::LAST_DATA_BIT)
                  && (state == smbus_pkg::D_WHI);

  // Read data for the current pointer; unmapped reads give a fixed word
  always_comb begin
    case (ptr)
      smbus_pkg::REG_CHARGE_SETPOINT: rd_word = setpoint;
      smbus_pkg::REG_VOLTAGE_CEILING: rd_word = ceiling;
      default:                        rd_word = smbus_pkg::UNMAPPED_READ;
    endcase
  end

  // Bus sequencer; SDA is only changed on SCL falling edges
  always_ff @(posedge i_link_clk) begin
    if (link_rst) begin
      state      <= smbus_pkg::D_IDLE;
      bit_cnt    <= 4'h0;
      sda_oe     <= 1'h0;
      shreg      <= 8'h00;
      tx         <= 8'h00;
      master_ack <= 1'h0;
    end else if (start_seen) begin
      state   <= smbus_pkg::D_ADDR;
      bit_cnt <= 4'hf; // SCL fall closing START wraps it to 0
      sda_oe  <= 1'h0;
    end else if (stop_seen) begin
      state   <= smbus_pkg::D_IDLE;
      bit_cnt <= 4'h0;
      sda_oe  <= 1'h0;
    end else if (state != smbus_pkg::D_IDLE &&
                 state != smbus_pkg::D_IGNORE) begin
      if (scl_rise) begin
        if (bit_cnt != smbus_pkg::ACK_SLOT) begin
          shreg <= {shreg[6:0], sda_f};
        end else begin
          master_ack <= ~sda_f;
        end
      end
      if (scl_fall) begin
        if (bit_cnt == smbus_pkg::LAST_DATA_BIT) begin
          bit_cnt <= smbus_pkg::ACK_SLOT;
          case (state)
            smbus_pkg::D_ADDR: sda_oe <= addr_hit;
            smbus_pkg::D_REG:  sda_oe <= 1'h1;
            smbus_pkg::D_WLO:  sda_oe <= 1'h1;
            smbus_pkg::D_WHI:  sda_oe <= 1'h1;
            default:           sda_oe <= 1'h0; // Master acks reads
          endcase
        end else if (bit_cnt == smbus_pkg::ACK_SLOT) begin
          bit_cnt <= 4'h0;
          sda_oe  <= 1'h0;
          case (state)
            smbus_pkg::D_ADDR: begin
              if (!addr_hit) begin
                state <= smbus_pkg::D_IGNORE;
              end else if (shreg[0] == smbus_pkg::DIR_READ) begin
                state  <= smbus_pkg::D_RLO;
                tx     <= rd_word[7:0];
                sda_oe <= ~rd_word[7];
              end else begin
                state <= smbus_pkg::D_REG;
              end
            end
            smbus_pkg::D_REG: state <= smbus_pkg::D_WLO;
            smbus_pkg::D_WLO: state <= smbus_pkg::D_WHI;
            smbus_pkg::D_RLO: begin
              if (master_ack) begin
                state  <= smbus_pkg::D_RHI;
                tx     <= rd_word[15:8];
                sda_oe <= ~rd_word[15];
              end else begin
                state <= smbus_pkg::D_IGNORE;
              end
            end
            default: state <= smbus_pkg::D_IGNORE;
          endcase
        end else begin
          bit_cnt <= bit_cnt + 4'h1;
          if (state == smbus_pkg::D_RLO || state == smbus_pkg::D_RHI) begin
            tx     <= {tx[6:0], 1'h0};
            sda_oe <= ~tx[6];
          end
        end
      end
    end
  end

  // Register pointer and low byte capture
  always_ff @(posedge i_link_clk) begin
    if (link_rst) begin
      ptr     <= 8'h00;
      lo_byte <= 8'h00;
    end else if (scl_fall && bit_cnt == smbus_pkg::LAST_DATA_BIT) begin
      if (state == smbus_pkg::D_REG) begin
        ptr <= shreg;
      end
      if (state == smbus_pkg::D_WLO) begin
        lo_byte <= shreg;
      end
    end
  end

  // Register update only on a complete word
  always_ff @(posedge i_link_clk) begin
    if (link_rst) begin
      setpoint <= smbus_pkg::SETPOINT_RESET;
      ceiling  <= smbus_pkg::CEILING_RESET;
      wr_reg   <= 8'h00;
      wr_data  <= 16'h0000;
      wr_tgl   <= 1'h0;
    end else if (commit) begin
      if (ptr == smbus_pkg::REG_CHARGE_SETPOINT) begin
        setpoint <= {shreg, lo_byte};
      end
      if (ptr == smbus_pkg::REG_VOLTAGE_CEILING) begin
        ceiling <= {shreg, lo_byte};
      end
      wr_reg  <= ptr;
      wr_data <= {shreg, lo_byte};
      wr_tgl  <= ~wr_tgl;
    end
  end

  // Open-drain data pin; SCL is never driven by this end
  assign link.dev_sda_out = 1'h0;
  assign link.dev_sda_oe  = sda_oe;

  // Write event crosses as a toggle; word is stable for a whole byte time
  bit_sync #(.RESET_VAL(1'h0)) u_tgl_sync (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_async (wr_tgl),
    .o_level (tgl_s)
  );

  // Report each completed write once
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      tgl_q         <= 1'h0;
      o_write_valid <= 1'h0;
      o_write_reg   <= 8'h00;
      o_write_data  <= 16'h0000;
    end else begin
      tgl_q         <= tgl_s;
      o_write_valid <= tgl_s ^ tgl_q;
      if (tgl_s ^ tgl_q) begin
        o_write_reg  <= wr_reg;
        o_write_data <= wr_data;
      end
    end
  end

  // Inactivity watchdog; only setpoint or ceiling writes rearm it
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      wd_cnt          <= 36'h0;
      o_charge_enable <= 1'h0;
    end else if ((tgl_s ^ tgl_q) &&
                 (wr_reg == smbus_pkg::REG_CHARGE_SETPOINT ||
                  wr_reg == smbus_pkg::REG_VOLTAGE_CEILING)) begin
      wd_cnt          <= 36'h0;
      o_charge_enable <= 1'h1;
    end else if (o_charge_enable) begin
      if (wd_cnt == WATCHDOG_CYCLES - 36'h1) begin
        o_charge_enable <= 1'h0;
      end else begin
        wd_cnt <= wd_cnt + 36'h1;
      end
    end
  end

endmodule : smbus_device

// file: logic/smbus_host.sv
// SMBus master issuing write-word and read-word transfers.
// Assumes i_clk is the only clock; SCL is divided down from it.
module smbus_host (
  // Clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_reset,
  // Link pins
  smbus_link_if.host         link,
  // Command
  input  wire logic          i_cmd_valid,
  input  wire logic          i_cmd_read,
  input  wire logic [7:0]    i_cmd_reg,
  input  wire logic [15:0]   i_cmd_wdata,
  // Status and result
  output logic               o_busy,
  output logic               o_done,
  output logic               o_nack,
  output logic [15:0]        o_rdata
);

  smbus_pkg::host_state_t state;
  logic [15:0] qcnt;
  logic [1:0]  phase;
  logic        tick;
  logic [3:0]  bit_idx;
  logic [2:0]  step;
  logic [7:0]  shreg;
  logic        rd_op;
  logic [7:0]  reg_q;
  logic [15:0] wdata_q;
  logic        restart;
  logic        got_nack;
  logic        rx;
  logic [2:0]  last_step;
  logic        scl_oe;
  logic        sda_oe;
  logic        sda_f;

  // Byte sent at each step of a transfer
  function automatic logic [7:0] tx_byte(input logic [2:0] s,
                                         input logic       rd,
                                         input logic [7:0] r,
                                         input logic [15:0] w);
    case (s)
      3'h0:    tx_byte = {smbus_pkg::DEV_ADDR, smbus_pkg::DIR_WRITE};
      3'h1:    tx_byte = r;
      3'h2:    tx_byte = rd ? {smbus_pkg::DEV_ADDR, smbus_pkg::DIR_READ}
                            : w[7:0];
      default: tx_byte = w[15:8];
    endcase
  endfunction : tx_byte

  // Data line as seen back from the bus
  bit_sync #(.RESET_VAL(1'h1)) u_sda_sync (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_async (link.sda),
    .o_level (sda_f)
  );

  assign rx        = rd_op && (step >= 3'h3);
  assign last_step = rd_op ? 3'h4 : 3'h3;
  assign tick      = (state != smbus_pkg::H_IDLE) &&
                     (qcnt == smbus_pkg::SCL_QUARTER_CYCLES - 16'h1);

  // Quarter-period timebase
  always_ff @(posedge i_clk) begin
    if (i_reset || state == smbus_pkg::H_IDLE) begin
      qcnt  <= 16'h0;
      phase <= 2'h0;
    end else if (tick) begin
      qcnt  <= 16'h0;
      phase <= phase + 2'h1;
    end else begin
      qcnt <= qcnt + 16'h1;
    end
  end

  // Transfer sequencer; SDA moves in quarter 0 while SCL is low, except START in quarter 1 and STOP in quarter 2 with SCL high
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state    <= smbus_pkg::H_IDLE;
      scl_oe   <= 1'h0;
      sda_oe   <= 1'h0;
      bit_idx  <= 4'h0;
      step     <= 3'h0;
      shreg    <= 8'h00;
      rd_op    <= 1'h0;
      reg_q    <= 8'h00;
      wdata_q  <= 16'h0000;
      restart  <= 1'h0;
      got_nack <= 1'h0;
      o_busy   <= 1'h0;
      o_done   <= 1'h0;
      o_nack   <= 1'h0;
      o_rdata  <= 16'h0000;
    end else begin
      o_done <= 1'h0;
      case (state)
        smbus_pkg::H_IDLE: begin
          if (i_cmd_valid) begin
            state   <= smbus_pkg::H_START;
            rd_op   <= i_cmd_read;
            reg_q   <= i_cmd_reg;
            wdata_q <= i_cmd_wdata;
            step    <= 3'h0;
            o_busy  <= 1'h1;
            o_nack  <= 1'h0;
          end
        end
        smbus_pkg::H_START: begin
          if (tick && phase == 2'h1) begin
            sda_oe <= 1'h1;
          end
          if (tick && phase == 2'h3) begin
            scl_oe  <= 1'h1;
            state   <= smbus_pkg::H_BYTE;
            bit_idx <= 4'h0;
            shreg   <= tx_byte(step, rd_op, reg_q, wdata_q);
          end
        end
        smbus_pkg::H_BYTE: begin
          if (tick) begin
            case (phase)
              2'h0: begin
                if (bit_idx != smbus_pkg::ACK_SLOT) begin
                  sda_oe <= ~rx & ~shreg[7];
                end else begin
                  sda_oe <= rx && (step != last_step);
                end
              end
              2'h1: scl_oe <= 1'h0;
              2'h2: begin
                if (bit_idx != smbus_pkg::ACK_SLOT) begin
                  shreg <= {shreg[6:0], sda_f};
                end else if (!rx) begin
                  got_nack <= sda_f;
                end
              end
              default: begin
                scl_oe <= 1'h1;
                if (bit_idx != smbus_pkg::ACK_SLOT) begin
                  bit_idx <= bit_idx + 4'h1;
                end else begin
                  bit_idx <= 4'h0;
                  if (rx && step == 3'h3) begin
                    o_rdata[7:0] <= shreg;
                  end
                  if (rx && step == 3'h4) begin
                    o_rdata[15:8] <= shreg;
                  end
                  if ((!rx && got_nack) || step == last_step) begin
                    state   <= smbus_pkg::H_STOP;
                    restart <= 1'h0;
                    o_nack  <= !rx && got_nack;
                  end else if (rd_op && step == 3'h1) begin
                    state   <= smbus_pkg::H_STOP;
                    restart <= 1'h1;
                    step    <= 3'h2;
                  end else begin
                    step  <= step + 3'h1;
                    shreg <= tx_byte(step + 3'h1, rd_op, reg_q, wdata_q);
                  end
                end
              end
            endcase
          end
        end
        smbus_pkg::H_STOP: begin
          if (tick) begin
            case (phase)
              2'h0: sda_oe <= 1'h1;
              2'h1: scl_oe <= 1'h0;
              2'h2: sda_oe <= 1'h0;
              default: begin
                if (restart) begin
                  state <= smbus_pkg::H_START;
                end else begin
                  state  <= smbus_pkg::H_IDLE;
                  o_busy <= 1'h0;
                  o_done <= 1'h1;
                end
              end
            endcase
          end
        end
        default: state <= smbus_pkg::H_IDLE;
      endcase
    end
  end

  // Open-drain pins
  assign link.host_scl_out = 1'h0;
  assign link.host_scl_oe  = scl_oe;
  assign link.host_sda_out = 1'h0;
  assign link.host_sda_oe  = sda_oe;

endmodule : smbus_host

// file: tb/smbus_link_properties.sv
// Checker for the SMBus link between the master and the word slave.
// Assumes the resolved lines and all drive enables of one link.
module smbus_link_properties (
  // Clocks and reset
  input  wire logic i_clk,
  input  wire logic i_reset,
  input  wire logic i_link_clk,
  // Link signals
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic host_scl_oe,
  input  wire logic host_sda_oe,
  input  wire logic dev_sda_oe
);
  logic       scl_prev;
  logic       sda_prev;
  logic [3:0] bit_idx;
  logic [2:0] byte_idx;
  logic [7:0] shift;
  logic       rd;
  logic       idle;
  wire logic  scl_rise = scl & ~scl_prev;
  wire logic  start = scl & scl_prev & sda_prev & ~sda;
  wire logic  stop = scl & scl_prev & ~sda_prev & sda;
  wire logic  ack = scl_rise & (bit_idx == smbus_pkg::ACK_SLOT);

  // Line history; reset reads as released lines
  always_ff @(posedge i_clk) begin
    scl_prev <= i_reset | scl;
    sda_prev <= i_reset | sda;
  end

  // Position in the frame, restarted by every START
  always_ff @(posedge i_clk) begin
    if (i_reset || start) begin
      bit_idx  <= 4'h0;
      byte_idx <= 3'h0;
    end else if (scl_rise) begin
      bit_idx  <= ack ? 4'h0 : bit_idx + 4'h1;
      byte_idx <= byte_idx + 3'(ack);
      shift    <= ack ? shift : {shift[6:0], sda};
    end
  end

  // Direction of the frame and bus idle between STOP and START
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rd <= 1'b0;
    end else if (ack && byte_idx == 3'h0) begin
      rd <= shift[0];
    end
    idle <= i_reset | stop | (idle & ~start);
  end

  property p_sda_scl_low;
    @(posedge i_clk) disable iff (i_reset) $changed(dev_sda_oe) |-> !scl;
  endproperty
  a_sda_scl_low: assert property (p_sda_scl_low)
    else $error("device moved SDA while SCL high");
  property p_follows_host;
    @(posedge i_clk) disable iff (i_reset)
      $rose(dev_sda_oe) |-> host_scl_oe;
  endproperty
  a_follows_host: assert property (p_follows_host)
    else $error("device pulled SDA without master holding SCL");
  property p_reset_quiet;
    @(posedge i_link_clk) i_reset [*8] |-> !dev_sda_oe;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("device drove SDA under reset");
  property p_idle_quiet;
    @(posedge i_clk) disable iff (i_reset) idle |-> !dev_sda_oe;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("device drove SDA after STOP");
  property p_addr_quiet;
    @(posedge i_clk) disable iff (i_reset)
      !idle && byte_idx == 3'h0 && bit_idx < 4'h8 |-> !dev_sda_oe;
  endproperty
  a_addr_quiet: assert property (p_addr_quiet)
    else $error("device drove SDA during control byte");
  property p_ctrl_ack;
    @(posedge i_clk) disable iff (i_reset) ack && byte_idx == 3'h0 &&
      shift[7:1] == smbus_pkg::DEV_ADDR |-> !sda;
  endproperty
  a_ctrl_ack: assert property (p_ctrl_ack)
    else $error("own address not acknowledged");
  property p_reg_ack;
    @(posedge i_clk) disable iff (i_reset)
      ack && byte_idx == 3'h1 && !rd |-> !sda;
  endproperty
  a_reg_ack: assert property (p_reg_ack)
    else $error("register byte not acknowledged");
  property p_ctrl_code;
    @(posedge i_clk) disable iff (i_reset) ack && byte_idx == 3'h0 |->
      shift[7:1] == smbus_pkg::DEV_ADDR;
  endproperty
  a_ctrl_code: assert property (p_ctrl_code)
    else $error("control byte carries wrong address");
  property p_read_end;
    @(posedge i_clk) disable iff (i_reset)
      ack && rd && byte_idx == 3'h2 |-> sda;
  endproperty
  a_read_end: assert property (p_read_end)
    else $error("high read byte was acknowledged");

  // Main scenarios seen on the link
  c_write: cover property (@(posedge i_clk) ack && byte_idx == 3'h3);
  c_read: cover property (@(posedge i_clk) ack && rd && byte_idx == 3'h2);
  c_stop: cover property (@(posedge i_clk) stop);
  c_start: cover property (@(posedge i_clk) start && host_sda_oe);
endmodule : smbus_link_properties

// file: tb/tb.sv
// Bench: master and slave on one link, and a second slave whose lines
// the bench drives itself. Assumes a free-running link clock.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned Q = 50;        // Bench quarter SCL, in cycles
  localparam logic [35:0] WDOG = 36'd8000; // Short watchdog for the run
  logic        clk;
  logic        reset;
  logic        link_clk;
  logic        cmd_valid;
  logic        cmd_read;
  logic [7:0]  cmd_reg;
  logic [15:0] cmd_wdata;
  logic        busy;
  logic        done;
  logic        nack;
  logic [15:0] rdata;
  logic        wv_a;
  logic        wv_b;
  logic        chg_a;
  logic        chg_b;
  logic [7:0]  wreg_a;
  logic [7:0]  wreg_b;
  logic [15:0] wdata_a;
  logic [15:0] wdata_b;
  int          miscompares;
  int          n_compared;
  int          nwr_a;
  int          nwr_b;
  smbus_link_if link_a ();
  smbus_link_if link_b ();

  smbus_host i_smbus_host (.i_clk(clk), .i_reset(reset), .link(link_a),
    .i_cmd_valid(cmd_valid), .i_cmd_read(cmd_read), .i_cmd_reg(cmd_reg),
    .i_cmd_wdata(cmd_wdata), .o_busy(busy), .o_done(done), .o_nack(nack),
    .o_rdata(rdata));
  smbus_device #(.WATCHDOG_CYCLES(WDOG)) i_smbus_device (.i_clk(clk),
    .i_reset(reset), .i_link_clk(link_clk), .link(link_a),
    .o_write_valid(wv_a), .o_write_reg(wreg_a), .o_write_data(wdata_a),
    .o_charge_enable(chg_a));
  smbus_device #(.WATCHDOG_CYCLES(WDOG)) i_smbus_device_b (.i_clk(clk),
    .i_reset(reset), .i_link_clk(link_clk), .link(link_b),
    .o_write_valid(wv_b), .o_write_reg(wreg_b), .o_write_data(wdata_b),
    .o_charge_enable(chg_b));
  smbus_link_properties i_smbus_link_properties (.i_clk(clk),
    .i_reset(reset), .i_link_clk(link_clk), .scl(link_a.scl),
    .sda(link_a.sda), .host_scl_oe(link_a.host_scl_oe),
    .host_sda_oe(link_a.host_sda_oe), .dev_sda_oe(link_a.dev_sda_oe));

  // Clocks; link clock phase is unrelated to the system clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #3.7;
    forever #24 link_clk = ~link_clk;
  end

  // Count reported word writes of each slave
  always @(posedge clk) begin
    if (wv_a === 1'b1) nwr_a++;
    if (wv_b === 1'b1) nwr_b++;
  end

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic end_sim;
    $display("compared %0d miscompared %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim

  // One master command, bounded wait for completion
  task automatic host_cmd(input logic rd, input logic [7:0] r,
                          input logic [15:0] w);
    int n;
    cmd_read = rd;
    cmd_reg = r;
    cmd_wdata = w;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    cmp({15'h0, busy}, 16'h0001);
    for (n = 0; n < 60000 && done !== 1'b1; n++) @(negedge clk);
    if (done !== 1'b1) begin
      miscompares++;
      end_sim();
    end
  endtask : host_cmd

  task automatic quarter;
    repeat (Q) @(negedge clk);
  endtask : quarter

  // Bench-driven master on the second link, released bus before START
  task automatic bb_start;
    quarter();
    link_b.host_sda_oe = 1'b1;
    quarter();
    link_b.host_scl_oe = 1'b1;
    quarter();
  endtask : bb_start

  task automatic bb_stop;
    link_b.host_sda_oe = 1'b1;
    quarter();
    link_b.host_scl_oe = 1'b0;
    quarter();
    link_b.host_sda_oe = 1'b0;
    quarter();
  endtask : bb_stop

  // Nine clocks, MSB first; SDA sampled mid high phase
  task automatic bb_xfer(input logic [8:0] v, output logic [8:0] s);
    for (int i = 8; i >= 0; i--) begin
      link_b.host_sda_oe = ~v[i];
      quarter();
      link_b.host_scl_oe = 1'b0;
      quarter();
      s[i] = link_b.sda;
      quarter();
      link_b.host_scl_oe = 1'b1;
      quarter();
    end
  endtask : bb_xfer

  task automatic bb_wr(input logic [7:0] v, input logic exp_nack);
    logic [8:0] s;
    bb_xfer({v, 1'b1}, s);
    cmp({15'h0, s[0]}, {15'h0, exp_nack});
  endtask : bb_wr

  task automatic b_flow;
    logic [8:0] lo;
    logic [8:0] hi;
    bb_start();
    bb_wr({7'h0a, smbus_pkg::DIR_WRITE}, 1'b1);
    bb_stop();
    bb_start();
    bb_wr({smbus_pkg::DEV_ADDR, smbus_pkg::DIR_WRITE}, 1'b0);
    bb_wr(smbus_pkg::REG_VOLTAGE_CEILING, 1'b0);
    bb_wr(8'h5a, 1'b0);
    bb_stop();
    cmp(16'(nwr_b), 16'h0000);
    bb_start();
    bb_wr({smbus_pkg::DEV_ADDR, smbus_pkg::DIR_WRITE}, 1'b0);
    bb_wr(smbus_pkg::REG_VOLTAGE_CEILING, 1'b0);
    bb_stop();
    bb_start();
    bb_wr({smbus_pkg::DEV_ADDR, smbus_pkg::DIR_READ}, 1'b0);
    bb_xfer(9'h1fe, lo);
    bb_xfer(9'h1ff, hi);
    bb_stop();
    cmp({hi[8:1], lo[8:1]}, smbus_pkg::CEILING_RESET);
    bb_start();
    bb_wr({smbus_pkg::DEV_ADDR, smbus_pkg::DIR_WRITE}, 1'b0);
    bb_wr(smbus_pkg::REG_VOLTAGE_CEILING, 1'b0);
    bb_wr(8'hef, 1'b0);
    bb_wr(8'hbe, 1'b0);
    bb_stop();
    cmp(16'(nwr_b), 16'h0001);
    cmp({8'h0, wreg_b}, 16'h0015);
    cmp(wdata_b, 16'hbeef);
    cmp({15'h0, chg_b}, 16'h0001);
  endtask : b_flow

  // Reset long enough for the link side, a write on the first link, then both links at once
  initial begin
    miscompares = 0;
    n_compared = 0;
    nwr_a = 0;
    nwr_b = 0;
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    cmd_reg = 8'h00;
    cmd_wdata = 16'h0000;
    link_b.host_scl_out = 1'b0;
    link_b.host_sda_out = 1'b0;
    link_b.host_scl_oe = 1'b0;
    link_b.host_sda_oe = 1'b0;
    reset = 1'b1;
    repeat (80) @(negedge clk);
    reset = 1'b0;
    repeat (100) @(negedge clk);
    cmp({15'h0, chg_a}, 16'h0000);
    cmp(wdata_a, 16'h0000);
    host_cmd(1'b0, smbus_pkg::REG_CHARGE_SETPOINT, 16'h41a0);
    cmp({15'h0, nack}, 16'h0000);
    cmp({8'h0, wreg_a}, 16'h0014);
    cmp(wdata_a, 16'h41a0);
    cmp(16'(nwr_a), 16'h0001);
    cmp({15'h0, chg_a}, 16'h0001);
    fork
      host_cmd(1'b1, smbus_pkg::REG_CHARGE_SETPOINT, 16'h0000);
      b_flow();
    join
    cmp(rdata, 16'h41a0);
    cmp({15'h0, nack}, 16'h0000);
    cmp({15'h0, chg_a}, 16'h0000);
    end_sim();
  end
endmodule : tb
